// ===== hdl/cell_cluster.sv
// Cell cluster: ten logic cells, shared control generation, AXI4-Lite setup.
// Assumes all inputs synchronous to aclk; cluster clocks become edge ticks.
// How it works
// - Ten logic cells share one local interconnect inside the cluster.
// - Cluster makes two clocks, two enables, two clears, sclr, aload, sload, addnsub.
// - Each cluster clock has its own enable; cells on a clock use its enable.
// - Second clock may be the inverse of the first, giving both edges.
// - A low enable suppresses every edge of its clock for its cells.
// - Asynchronous load presets the register when the load data is high.
// - The add/subtract select makes each cell a one-bit adder or subtractor.
// - Shared controls come from six row clocks and the local interconnect.
// - Each cell holds a four-input table for any function of four inputs.
// - Each register acts as D, T, JK or SR flip-flop.
// - Register inputs: data, load data, clock, enable, clear, load control.
// - Asynchronous load data is the fourth data input.
// - Combinational use routes the table result around the register.
// - Three outputs per cell, each picking table result or register.
// - Table and register may serve unrelated functions at once.
// - The register may feed back into its own cell's table.
// - Registered and unregistered table results may appear together.
// - A table chain passes each table result to the next cell.
// - A register chain passes each register to the next cell's register.
// - Left and right neighbours drive local inputs through direct links.
// - Clock and clear may come from row lines; other controls only locally.
// - Subtraction inverts the second operand and forces carry-in one.
// - Normal mode ignores add/subtract; arithmetic mode honours it.
`timescale 1ns/100ps
module cell_cluster #(
  parameter int CELLS = cluster_pkg::CELLS
) (
  input  logic                                 aclk,
  input  logic                                 aresetn,
  input  logic [cluster_pkg::ADDR_W-1:0]       awaddr,
  input  logic                                 awvalid,
  output logic                                 awready,
  input  logic [31:0]                          wdata,
  input  logic [3:0]                           wstrb,
  input  logic                                 wvalid,
  output logic                                 wready,
  output logic [1:0]                           bresp,
  output logic                                 bvalid,
  input  logic                                 bready,
  input  logic [cluster_pkg::ADDR_W-1:0]       araddr,
  input  logic                                 arvalid,
  output logic                                 arready,
  output logic [31:0]                          rdata,
  output logic [1:0]                           rresp,
  output logic                                 rvalid,
  input  logic                                 rready,
  input  logic [5:0]                           row_clk,
  input  logic [cluster_pkg::LOCAL_W-1:0]      ctrl_local,
  input  logic [CELLS-1:0][3:0]                route_in,
  input  logic [CELLS-1:0]                     left_link,
  input  logic [CELLS-1:0]                     right_link,
  output logic [CELLS-1:0]                     route_a,
  output logic [CELLS-1:0]                     route_b,
  output logic                                 carry_out,
  output logic                                 chain_out
);

  if (CELLS < 2 || CELLS > cluster_pkg::CELLS) begin : g_bad_cells
    $error("CELLS must lie between 2 and the register map size");
  end

  function automatic logic pick(input logic [2:0] s, input logic [5:0] rc, input logic lc);
    pick = (s < cluster_pkg::SRC_LOCAL) ? rc[s] : (s == cluster_pkg::SRC_LOCAL) ? lc : 1'b0;
  endfunction : pick

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b])
        r[8*b +: 8] = d[8*b +: 8];
    end
    merge = r;
  endfunction : merge

  // Register file and bus slave state.
  logic [31:0] cfg_reg [CELLS];
  logic [31:0] ctrl_reg;
  logic        awready_reg;
  logic        wready_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        arready_reg;
  logic        rvalid_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rdata_reg;

  // Cluster state.
  logic        clk1_reg;
  logic        clk2_reg;
  logic [CELLS-1:0] local_reg;
  logic [CELLS-1:0] route_a_reg;
  logic [CELLS-1:0] route_b_reg;
  logic        carry_out_reg;
  logic        chain_out_reg;

  // Cell-facing nets.
  cluster_pkg::cell_cfg_t [CELLS-1:0] cfg_s;
  cluster_pkg::cell_ctl_t [CELLS-1:0] ctl_s;
  logic [CELLS-1:0][3:0] dat;
  logic [CELLS-1:0] lut_v;
  logic [CELLS-1:0] q_vec;
  logic [CELLS:0]   carry_v;
  logic [CELLS-1:0] route_a_next;
  logic [CELLS-1:0] route_b_next;
  logic [CELLS-1:0] local_next;

  // Write side: both channels are taken together, one write at a time.
  wire                            aw_take  = awvalid && wvalid && !awready_reg && !bvalid_reg;
  wire                            wr_fire  = awvalid && awready_reg;
  wire [5:0]                      wr_idx   = awaddr[7:2];
  wire                            wr_cfg   = wr_idx < CELLS;
  wire                            wr_ctl   = awaddr[7:2] == cluster_pkg::CTRL_OFF[7:2];
  wire [cluster_pkg::CIDX_W-1:0]  wr_ci    = wr_cfg ? wr_idx[cluster_pkg::CIDX_W-1:0] : '0;
  wire [31:0]                     cfg_new  = merge(cfg_reg[wr_ci], wdata, wstrb);
  wire [31:0]                     ctrl_new = merge(ctrl_reg, wdata, wstrb);

  // Read side.
  wire                            ar_take  = arvalid && !arready_reg && !rvalid_reg;
  wire                            rd_fire  = arvalid && arready_reg;
  wire [5:0]                      rd_idx   = araddr[7:2];
  wire                            rd_cfg   = rd_idx < CELLS;
  wire                            rd_ctl   = araddr[7:2] == cluster_pkg::CTRL_OFF[7:2];
  wire                            rd_stat  = araddr[7:2] == cluster_pkg::STAT_OFF[7:2];
  wire [cluster_pkg::CIDX_W-1:0]  rd_ci    = rd_cfg ? rd_idx[cluster_pkg::CIDX_W-1:0] : '0;
  wire [31:0]                     stat_word = (32'(lut_v) << cluster_pkg::STAT_LUT_LSB) | 32'(q_vec);
  wire [31:0]                     rd_word  = rd_cfg ? cfg_reg[rd_ci] : rd_ctl ? ctrl_reg :
                                             rd_stat ? stat_word : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= cluster_pkg::RESP_OKAY;
    end else begin
      awready_reg <= aw_take;
      wready_reg  <= aw_take;
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= (wr_cfg || wr_ctl) ? cluster_pkg::RESP_OKAY : cluster_pkg::RESP_SLVERR;
      end else if (bready)
        bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < CELLS; i++)
        cfg_reg[i] <= cluster_pkg::CFG_RESET;
      ctrl_reg <= cluster_pkg::CTRL_RESET;
    end else if (wr_fire && wr_cfg)
      cfg_reg[wr_ci] <= cfg_new;
    else if (wr_fire && wr_ctl)
      ctrl_reg <= ctrl_new;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= cluster_pkg::RESP_OKAY;
      rdata_reg   <= 32'h0000_0000;
    end else begin
      arready_reg <= ar_take;
      if (rd_fire) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_word;
        rresp_reg  <= (rd_cfg || rd_ctl || rd_stat) ? cluster_pkg::RESP_OKAY : cluster_pkg::RESP_SLVERR;
      end else if (rready)
        rvalid_reg <= 1'b0;
    end
  end

  // Shared control generation from row clocks and local lines.
  wire [2:0] ck1_src = ctrl_reg[cluster_pkg::CK1_LSB +: cluster_pkg::SRC_W];
  wire [2:0] ck2_src = ctrl_reg[cluster_pkg::CK2_LSB +: cluster_pkg::SRC_W];
  wire [2:0] cl1_src = ctrl_reg[cluster_pkg::CLR1_LSB +: cluster_pkg::SRC_W];
  wire [2:0] cl2_src = ctrl_reg[cluster_pkg::CLR2_LSB +: cluster_pkg::SRC_W];
  wire       fall2   = ctrl_reg[cluster_pkg::FALL2_BIT];
  wire       clk1_lvl = pick(ck1_src, row_clk, ctrl_local[cluster_pkg::LC_CLK]);
  // Clock two as the inverse of clock one lets cells use the falling edge.
  wire       clk2_lvl = fall2 ? ~clk1_lvl : pick(ck2_src, row_clk, ctrl_local[cluster_pkg::LC_CLK]);
  wire       aclr1   = pick(cl1_src, row_clk, ctrl_local[cluster_pkg::LC_ACLR]);
  wire       aclr2   = pick(cl2_src, row_clk, ctrl_local[cluster_pkg::LC_ACLR]);
  wire       ena1    = ctrl_local[cluster_pkg::LC_ENA1];
  wire       ena2    = ctrl_local[cluster_pkg::LC_ENA2];
  wire       tick1   = clk1_lvl && !clk1_reg && ena1;
  wire       tick2   = clk2_lvl && !clk2_reg && ena2;
  wire       sclr    = ctrl_local[cluster_pkg::LC_SCLR];
  wire       aload   = ctrl_local[cluster_pkg::LC_ALOAD];
  wire       sload   = ctrl_local[cluster_pkg::LC_SLOAD];
  wire       addnsub = ctrl_local[cluster_pkg::LC_ADDNSUB];

  // Edge history starts high so a clock that is high at reset release gives no false edge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk1_reg <= 1'b1;
      clk2_reg <= 1'b1;
    end else begin
      clk1_reg <= clk1_lvl;
      clk2_reg <= clk2_lvl;
    end
  end

  // The first cell receives the select as its carry-in for the two's complement.
  assign carry_v[0] = addnsub;

  for (genvar i = 0; i < CELLS; i++) begin : g_cell
    localparam int P = (i == 0) ? CELLS - 1 : i - 1;
    logic [3:0] spec;
    // Code three gives the chained table, own register packing or the previous cell's registered local line.
    assign spec[0] = (i == 0) ? route_in[i][0] : lut_v[P];
    assign spec[1] = q_vec[i];
    assign spec[2] = local_reg[P];
    assign spec[3] = local_reg[P];
    assign cfg_s[i] = cluster_pkg::cell_cfg_t'(cfg_reg[i]);
    for (genvar k = 0; k < 4; k++) begin : g_in
      wire [1:0] s = cfg_s[i].in_sel[2*k +: 2];
      assign dat[i][k] = (s == 2'h0) ? route_in[i][k] : (s == 2'h1) ? left_link[i] :
                         (s == 2'h2) ? right_link[i] : spec[k];
    end
    assign ctl_s[i].tick  = cfg_s[i].clk_sel ? tick2 : tick1;
    assign ctl_s[i].aclr  = cfg_s[i].clk_sel ? aclr2 : aclr1;
    assign ctl_s[i].aload = aload;
    assign ctl_s[i].sclr  = sclr;
    assign ctl_s[i].sload = sload;
    // Each output picks table or register, so both may serve separate functions.
    assign route_a_next[i] = cfg_s[i].out_sel[0] ? q_vec[i] : lut_v[i];
    assign route_b_next[i] = cfg_s[i].out_sel[1] ? q_vec[i] : lut_v[i];
    assign local_next[i]   = cfg_s[i].out_sel[2] ? q_vec[i] : lut_v[i];

    logic_cell u_cell (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .cfg       (cfg_s[i]),
      .ctl       (ctl_s[i]),
      .dat       (dat[i]),
      .chain_in  ((i == 0) ? 1'b0 : q_vec[P]),
      .carry_in  (carry_v[i]),
      .addnsub   (addnsub),
      .lut_out   (lut_v[i]),
      .reg_q     (q_vec[i]),
      .carry_out (carry_v[i+1])
    );
  end

  // Local feedback is registered to break the loop a cell's own output would close.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      local_reg     <= '0;
      route_a_reg   <= '0;
      route_b_reg   <= '0;
      carry_out_reg <= 1'b0;
      chain_out_reg <= 1'b0;
    end else begin
      local_reg     <= local_next;
      route_a_reg   <= route_a_next;
      route_b_reg   <= route_b_next;
      carry_out_reg <= carry_v[CELLS];
      chain_out_reg <= q_vec[CELLS-1];
    end
  end

  assign awready   = awready_reg;
  assign wready    = wready_reg;
  assign bvalid    = bvalid_reg;
  assign bresp     = bresp_reg;
  assign arready   = arready_reg;
  assign rvalid    = rvalid_reg;
  assign rresp     = rresp_reg;
  assign rdata     = rdata_reg;
  assign route_a   = route_a_reg;
  assign route_b   = route_b_reg;
  assign carry_out = carry_out_reg;
  assign chain_out = chain_out_reg;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence wr_offer_s;
    awvalid && wvalid && !awready && !bvalid;
  endsequence
  sequence wr_done_s;
    awready && wready ##1 bvalid;
  endsequence

  axi_write_order_a: assert property (wr_offer_s |=> wr_done_s)
    else $error("write not answered two cycles after offer");

  clear_holds_zero_a: assert property (ctl_s[0].aclr |=> !q_vec[0])
    else $error("asserted clear did not zero the register");

  preset_one_a: assert property (!ctl_s[0].aclr && aload && dat[0][3] |=> q_vec[0])
    else $error("load with high data did not preset");

  enable_gates_a: assert property (!ena1 && !cfg_s[0].clk_sel && !aclr1 && !aload |=> $stable(q_vec[0]))
    else $error("register moved while its enable was low");

  tick_needs_ena_a: assert property (tick1 |-> ena1 && !$past(clk1_lvl))
    else $error("clock one ticked without its enable or edge");

  falling_edge_a: assert property (fall2 && ena2 && $past(clk1_lvl) && !clk1_lvl |-> tick2)
    else $error("falling edge of clock one gave no tick on clock two");

  sub_carry_a: assert property (cfg_s[0].arith && addnsub |-> lut_v[0] == (dat[0][1] ^ ~dat[0][2] ^ 1'b1))
    else $error("subtract in first cell lacks inversion or carry-in");

  route_select_a: assert property (1'b1 |=> route_a[0] == $past(route_a_next[0]))
    else $error("route output does not follow its selection");

  reg_chain_shift_a: assert property (cfg_s[1].regchain && cfg_s[1].kind == cluster_pkg::FF_D &&
                                      ctl_s[1].tick && !ctl_s[1].aclr && !aload && !sclr && !sload
                                      |=> q_vec[1] == $past(q_vec[0]))
    else $error("register chain did not shift");

endmodule : cell_cluster

// ===== hdl/cluster_pkg.sv
// Shared constants and carrier types for the logic cell cluster.
// Assumes a 32-bit AXI4-Lite register bus with an 8-bit byte address.
package cluster_pkg;

  localparam int CELLS  = 10;
  localparam int CIDX_W = 4;
  localparam int ADDR_W = 8;

  // Register byte addresses; cell configuration words start at zero.
  localparam logic [7:0] CFG_BASE = 8'h00;
  localparam logic [7:0] CTRL_OFF = 8'h28;
  localparam logic [7:0] STAT_OFF = 8'h2c;

  localparam logic [31:0] CFG_RESET  = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET = 32'h0000_1fb8;

  // Control register fields: source codes 0..5 pick a row clock.
  localparam int SRC_W     = 3;
  localparam int CK1_LSB   = 0;
  localparam int CK2_LSB   = 3;
  localparam int FALL2_BIT = 6;
  localparam int CLR1_LSB  = 7;
  localparam int CLR2_LSB  = 10;
  localparam logic [2:0] SRC_LOCAL = 3'h6;
  localparam logic [2:0] SRC_OFF   = 3'h7;

  // Bit positions of the local interconnect control lines.
  localparam int LOCAL_W    = 8;
  localparam int LC_ENA1    = 0;
  localparam int LC_ENA2    = 1;
  localparam int LC_SCLR    = 2;
  localparam int LC_ALOAD   = 3;
  localparam int LC_SLOAD   = 4;
  localparam int LC_ADDNSUB = 5;
  localparam int LC_CLK     = 6;
  localparam int LC_ACLR    = 7;

  localparam int STAT_LUT_LSB = 16;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {FF_D, FF_T, FF_JK, FF_SR} ff_kind_t;

  // One configuration word per cell, bit 31 first.
  typedef struct packed {
    logic       regchain;
    logic       arith;
    logic       clk_sel;
    logic [2:0] out_sel;
    ff_kind_t   kind;
    logic [7:0] in_sel;
    logic [15:0] lut;
  } cell_cfg_t;

  typedef struct packed {
    logic tick;
    logic aclr;
    logic aload;
    logic sclr;
    logic sload;
  } cell_ctl_t;

endpackage : cluster_pkg

// ===== hdl/logic_cell.sv
// One logic cell: four-input table, carry logic and a configurable register.
// Assumes the cluster supplies edge ticks and already-selected control levels.
`timescale 1ns/100ps
module logic_cell (
  input  logic                   aclk,
  input  logic                   aresetn,
  input  cluster_pkg::cell_cfg_t cfg,
  input  cluster_pkg::cell_ctl_t ctl,
  input  logic [3:0]             dat,
  input  logic                   chain_in,
  input  logic                   carry_in,
  input  logic                   addnsub,
  output logic                   lut_out,
  output logic                   reg_q,
  output logic                   carry_out
);
  logic b_op;
  logic sum;
  logic d_in;
  logic q_next;

  // The select is ignored in normal mode so general logic never sees it.
  assign b_op      = cfg.arith ? (dat[2] ^ addnsub) : dat[2];
  assign sum       = dat[1] ^ b_op ^ carry_in;
  assign carry_out = cfg.arith ? ((dat[1] & b_op) | (carry_in & (dat[1] ^ b_op))) : carry_in;
  assign lut_out   = cfg.arith ? sum : cfg.lut[dat];
  assign d_in      = cfg.regchain ? chain_in : lut_out;

  // The fourth data input is the second control of the JK and SR kinds.
  always_comb begin
    unique case (cfg.kind)
      cluster_pkg::FF_D:  q_next = d_in;
      cluster_pkg::FF_T:  q_next = reg_q ^ d_in;
      cluster_pkg::FF_JK: q_next = (d_in & ~reg_q) | (~dat[3] & reg_q);
      cluster_pkg::FF_SR: q_next = d_in | (~dat[3] & reg_q);
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      reg_q <= 1'b0;
    else if (ctl.aclr)
      reg_q <= 1'b0;
    else if (ctl.aload)
      reg_q <= dat[3];
    else if (ctl.tick) begin
      if (ctl.sclr)
        reg_q <= 1'b0;
      else if (ctl.sload)
        reg_q <= dat[3];
      else
        reg_q <= q_next;
    end
  end

endmodule : logic_cell

// ===== bench/fabric_model.sv
// Routing fabric and neighbour clusters seen from one cell cluster.
// Assumes the bench commands row line 0 and the link levels once per cycle.
`timescale 1ns/100ps
module fabric_model #(
  parameter int CELLS = 10
) (
  input  wire logic             aclk,
  input  wire logic             row_cmd,
  input  wire logic [CELLS-1:0] lnk_l,
  input  wire logic [CELLS-1:0] lnk_r,
  output logic      [5:0]       row_clk = 6'h00,
  output logic      [CELLS-1:0] left_link = '0,
  output logic      [CELLS-1:0] right_link = '0
);
  logic [4:0] free_reg = 5'h00;

  // Spare row lines run free, so a wrong clock source shows up as stray ticks.
  always @(posedge aclk) begin
    free_reg   <= free_reg + 5'h01;
    row_clk    <= {free_reg, row_cmd};
    left_link  <= lnk_l;
    right_link <= lnk_r;
  end
endmodule : fabric_model

// ===== bench/cell_cluster_test.sv
// Self-checking bench for the cell cluster: setup bus, tables, registers, adder and register chain.
// Assumes the fabric model owns row clocks and links; a small model here predicts every result.
`timescale 1ns/100ps
module cell_cluster_test;
  localparam int N = cluster_pkg::CELLS;
  logic              aclk;
  logic              aresetn = 1'b0;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic              arvalid = 1'b0, rready = 1'b0, row_cmd = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid, carry_out, chain_out, ld, cl, sc;
  logic [1:0]        bresp, rresp, r, q, en;
  logic [3:0]        wstrb = 4'hf, x;
  logic [5:0]        row_clk;
  logic [7:0]        awaddr = 8'h00, araddr = 8'h00, ctrl_local = 8'h00;
  logic [7:0]        s [N];
  logic [15:0]       m [N];
  logic [31:0]       wdata = 32'h0000_0000, rdata, d;
  logic [63:0]       w;
  logic [N:0]        e;
  logic [N-1:0]      route_a, route_b, left_link, right_link, t, sh;
  logic [N-1:0]      lnk_l = '0, lnk_r = '0;
  logic [N-1:0][3:0] route_in = '0;
  int                n_errors = 0, checks = 0, seed = 32'h388b;

  cell_cluster #(.CELLS(N)) cell_cluster_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .row_clk, .ctrl_local, .route_in, .left_link, .right_link, .route_a, .route_b, .carry_out, .chain_out);
  fabric_model #(.CELLS(N)) fabric_model_inst (.aclk, .row_cmd, .lnk_l, .lnk_r, .row_clk, .left_link,
    .right_link);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  function automatic logic [31:0] rnd();
    return $random(seed);
  endfunction : rnd

  function automatic logic nxt(input int k, input logic v, input logic j, input logic d3, input logic tk,
                               input logic l, input logic c);
    if (c) return 1'b0;
    if (l) return d3;
    if (!tk) return v;
    case (k)
      0: return j;
      1: return v ^ j;
      2: return j ? (d3 ? !v : 1'b1) : (d3 ? 1'b0 : v);
      default: return j | (v & !d3);
    endcase
  endfunction : nxt

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
    checks++;
    if (g !== ex) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, ex, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] b, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= b;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin do @(posedge aclk); while (awready !== 1'b1); awvalid <= 1'b0; end
      begin do @(posedge aclk); while (wready !== 1'b1); wvalid <= 1'b0; end
    join
    while (bvalid !== 1'b1) @(posedge aclk);
    rs = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic cw(input logic [7:0] a, input logic [31:0] v);
    wr(a, v, 4'hf, r);
    chk("bresp", cluster_pkg::RESP_OKAY, r);
  endtask : cw

  // Row line 0 rises then falls, so clock one and its inverted twin each see one edge.
  task automatic pulse();
    cyc(2);
    row_cmd <= 1'b1;
    cyc(3);
    row_cmd <= 1'b0;
    cyc(3);
  endtask : pulse

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    cyc(3);
    aresetn <= 1'b1;
    rd(cluster_pkg::CTRL_OFF, d, r);
    chk("ctrl", cluster_pkg::CTRL_RESET, d);
    for (int i = 0; i < N; i++) begin
      rd(8'(4*i), d, r);
      chk("cfg", cluster_pkg::CFG_RESET, d);
    end
    rd(8'h30, d, r);
    chk("rresp", cluster_pkg::RESP_SLVERR, r);
    wr(cluster_pkg::STAT_OFF, 32'hffff_ffff, 4'hf, r);
    chk("bresp", cluster_pkg::RESP_SLVERR, r);
    cw(8'h00, 32'h1234_5678);
    wr(8'h00, 32'hffff_ffff, 4'h1, r);
    rd(8'h00, d, r);
    chk("strobe", 32'h1234_56ff, d);
    // Random tables with route, link and chained-table inputs; the add/subtract line must not matter here.
    repeat (6) begin
      for (int i = 0; i < N; i++) begin
        m[i] = 16'(rnd());
        for (int k = 0; k < 4; k++) s[i][2*k +: 2] = 2'(rnd() % (k == 0 ? 4 : 3));
        cw(8'(4*i), {8'h00, s[i], m[i]});
      end
      w = {rnd(), rnd()};
      route_in <= w[4*N-1:0];
      lnk_l <= w[63 -: N];
      lnk_r <= w[53 -: N];
      ctrl_local <= {2'b00, w[42], 5'h00};
      cyc(4);
      for (int i = 0; i < N; i++) begin
        for (int k = 0; k < 4; k++)
          case (s[i][2*k +: 2])
            2'h0: x[k] = route_in[i][k];
            2'h1: x[k] = lnk_l[i];
            2'h2: x[k] = lnk_r[i];
            default: x[k] = (i == 0) ? route_in[0][0] : t[i-1];
          endcase
        t[i] = m[i][x];
      end
      chk("route_a", t, route_a);
      chk("route_b", t, route_b);
      rd(cluster_pkg::STAT_OFF, d, r);
      chk("status", {6'h00, t, 16'h0000}, d & 32'h03ff03ff);
    end
    cw(cluster_pkg::CTRL_OFF, 32'h0000_1b40);
    q = 2'b00;
    for (int k = 0; k < 4; k++) begin
      cw(8'h00, {6'h02, 2'(k), 24'h00aaaa});
      cw(8'h04, {6'h0a, 2'(k), 24'h00aaaa});
      repeat (8) begin
        w = {rnd(), rnd()};
        ld = w[2:0] == 3'h0;
        cl = w[5:3] == 3'h0;
        en = w[7:6];
        sc = &en & (w[9:8] == 2'h0);
        route_in <= w[4*N+9:10];
        ctrl_local <= {cl, 3'h0, ld, sc, en};
        pulse();
        ctrl_local <= 8'h00;
        cyc(3);
        // A held load outranks the synchronous clear, which only acts on a tick.
        for (int i = 0; i < 2; i++) q[i] = nxt(k, q[i], w[10+4*i], w[13+4*i], en[i], ld, cl | (sc & !ld));
        chk("table", {w[14], w[10]}, route_a[1:0]);
        chk("register", q, route_b[1:0]);
      end
    end
    for (int i = 0; i < N; i++) cw(8'(4*i), 32'h4000_0000);
    repeat (6) begin
      w = {rnd(), rnd()};
      for (int i = 0; i < N; i++) route_in[i] <= {1'b0, w[20+i], w[i], 1'b0};
      ctrl_local <= {2'b00, w[40], 5'h00};
      cyc(4);
      e = {1'b0, w[N-1:0]} + {1'b0, w[40] ? ~w[N+19:20] : w[N+19:20]} + w[40];
      chk("sum", e[N-1:0], route_a);
      chk("carry", e[N], carry_out);
    end
    for (int i = 0; i < N; i++) cw(8'(4*i), 32'h8400_0000);
    route_in <= {N{4'h8}};
    ctrl_local <= 8'h08;
    cyc(3);
    ctrl_local <= 8'h01;
    cyc(3);
    sh = '1;
    for (int k = 0; k <= N; k++) begin
      chk("shift", sh, route_a);
      chk("chain", sh[N-1], chain_out);
      pulse();
      sh = sh << 1;
    end
    // Cell 0 feeds its own register back as data1 through an inverting table, so each tick toggles it.
    cw(8'h00, 32'h080c_3333);
    q[0] = 1'b0;
    repeat (3) begin
      pulse();
      q[0] = !q[0];
      chk("packed", {q[0], !q[0]}, {route_b[0], route_a[0]});
    end
    tally_and_finish();
  end

  // Generous limit: the whole sequence needs under two thousand cycles.
  initial begin
    repeat (30000) @(posedge aclk);
    n_errors++;
    tally_and_finish();
  end
endmodule : cell_cluster_test
